// ==== rtl/ise_ctrl.sv ====
// Contract
// - all-zero extended config means legacy mode, no buffering
// - no auto match plus window mode: stall and irq on address only; the code also raises byte-done for data bytes unless suppression is set
// - legacy mode holds SCL low after every byte until CPU services; the code does not hold after a transmitted byte the master NACKs
// - suppression bit: no byte-done for auto-acked non-stalling data bytes
// - every stall raises byte-done regardless of suppression
// - auto match without window mode ignores suppression
// - legacy mode ignores suppression, byte-done every byte
// - data byte-done posts only if flag cleared; else masked and stall
// - window mode: 32-byte RAM, never stall, auto ack received bytes; the code is stall-free only with auto match and suppression both set
// - auto match acks own address, nacks mismatch and idles to start
// - no auto match: set address flag, stall, address in data reg
// - direction bit one for master read, valid only when busy
// - busy set on hardware match, cleared at stop; status read only
// - own address holds 7 bits used only for auto match
// - window write: first data byte loads 5-bit base pointer
// - write data stored from base pointer, address increments per byte
// - reads return data from base pointer, incrementing per byte
// - base pointer changes only at start of write transactions
// - pointer byte above top location is not acknowledged
// - bytes past window end dropped, memory untouched
// - every start reloads current pointer from base pointer
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "ise_params.svh"
module ise_ctrl (
	input  wire logic            clk,
	input  wire logic            reset_n,
	input  wire logic [7:0]      reg_addr,
	input  wire logic [7:0]      reg_wdata,
	input  wire logic            reg_wr,
	input  wire logic            reg_rd,
	output logic      [7:0]      reg_rdata,
	input  wire logic            scl_in,
	input  wire logic            sda_in,
	output logic                 scl_out,
	output logic                 scl_oe_n,
	output logic                 sda_out,
	output logic                 sda_oe_n,
	output logic                 byte_done_irq,
	output ise_pkg::ise_state_t  bus_state
);
	import ise_pkg::*;

	logic            rst_a_ff;
	logic            rst_n;
	logic [1:0]      pins_q;
	logic            scl_q;
	logic            sda_q;
	logic            scl_prev_ff;
	logic            sda_prev_ff;
	logic            scl_rise;
	logic            scl_fall;
	logic            start_det;
	logic            stop_det;

	logic [7:0]      xcfg_ff;
	logic [6:0]      own_addr_ff;
	logic            cfg_en_ff;
	logic            bdf_ff;
	logic            scr_ack_ff;
	logic            addrf_ff;
	logic [7:0]      data_ff;
	ise_ptr_t        ram_idx_ff;
	logic            busy_ff;
	logic            dir_ff;
	ise_ptr_t        base_ff;
	ise_ptr_t        cur_ff;
	logic            ovf_ff;
	logic            first_ff;
	logic            pin_lo_ff;

	ise_state_t      state_ff;
	logic [7:0]      shift_ff;
	logic [3:0]      bit_cnt_ff;
	logic            is_addr_ff;
	logic            rd_dir_ff;
	logic            ack_ff;
	logic            ack_auto_ff;
	logic            hold_auto_ff;
	logic            hold_tx_ff;
	logic            m_ack_ff;
	logic            scl_oe_n_ff;
	logic            sda_oe_n_ff;
	logic [7:0]      rdata_ff;

	logic            auto_en;
	logic            ram_en;
	logic            sup_en;
	logic            addr_match;
	logic            ptr_bad;
	logic            rx_end;
	logic            tx_end;
	logic            auto_nack;
	logic            rx_stall_base;
	logic            rx_irq;
	logic            rx_stall;
	logic            rx_ack;
	logic            tx_irq;
	logic            tx_stall;
	logic            set_bdf;
	logic            scr_wr;
	logic            hold_ack;
	logic            bus_we;
	ise_ptr_t        bus_addr;
	logic [7:0]      bus_rd;
	logic [7:0]      cpu_rd;
	logic [7:0]      tx_src;
	logic            cpu_we;

	// reset release through two flops
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_a_ff <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_a_ff <= 1'b1;
			rst_n    <= rst_a_ff;
		end
	end

	ise_pin_sync #(.W(2)) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.din   ({scl_in, sda_in}),
		.dout  (pins_q)
	);
	assign scl_q = pins_q[1];
	assign sda_q = pins_q[0];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_prev_ff <= 1'b1;
			sda_prev_ff <= 1'b1;
		end else begin
			scl_prev_ff <= scl_q;
			sda_prev_ff <= sda_q;
		end
	end

	// bus events
	assign scl_rise  = scl_q & ~scl_prev_ff;
	assign scl_fall  = ~scl_q & scl_prev_ff;
	assign start_det = scl_q & scl_prev_ff & sda_prev_ff & ~sda_q;
	assign stop_det  = scl_q & scl_prev_ff & ~sda_prev_ff & sda_q;

	// mode decode; all-zero config is legacy mode
	assign auto_en = xcfg_ff[`ISE_XCFG_AUTO];
	assign ram_en  = xcfg_ff[`ISE_XCFG_RAM];
	assign sup_en  = xcfg_ff[`ISE_XCFG_SUP];

	assign addr_match = (shift_ff[7:1] == own_addr_ff);
	assign ptr_bad    = (shift_ff > `ISE_PTR_MAX);
	assign rx_end     = (state_ff == ST_RX) && scl_fall &&
	                    (bit_cnt_ff == `ISE_BYTE_BITS);
	assign tx_end     = (state_ff == ST_TX_ACK) && scl_fall;

	// received byte: stall and byte-done decisions
	assign auto_nack     = is_addr_ff & auto_en & ~addr_match;
	assign rx_stall_base = ~ram_en | (is_addr_ff & ~auto_en);
	assign rx_irq        = ~auto_nack &
	                       (rx_stall_base | ~(sup_en & ram_en));
	assign rx_stall      = ~auto_nack & (rx_stall_base |
	                       (rx_irq & ~is_addr_ff & bdf_ff));
	assign rx_ack        = is_addr_ff ? addr_match :
	                       ~(first_ff & ptr_bad);

	// transmitted byte
	assign tx_irq   = ~(sup_en & ram_en);
	assign tx_stall = m_ack_ff & (~ram_en | (tx_irq & bdf_ff));

	assign set_bdf  = (rx_end & rx_irq) | (tx_end & tx_irq);
	assign scr_wr   = reg_wr && (reg_addr == `ISE_OFS_SCR);
	assign hold_ack = hold_auto_ff ? ack_auto_ff : reg_wdata[`ISE_SCR_ACK];

	// window memory
	assign bus_we   = rx_end & ram_en & ~is_addr_ff &
	                  ~first_ff & ~ovf_ff;
	assign bus_addr = (state_ff == ST_TX_ACK) ?
	                  ise_ptr_t'(cur_ff + 5'h01) : cur_ff;
	assign tx_src   = ram_en ? bus_rd : data_ff;
	assign cpu_we   = reg_wr && (reg_addr == `ISE_OFS_RAM_DAT);

	ise_ram #(.AW(5), .DW(8)) u_ram (
		.clk     (clk),
		.a_we    (bus_we),
		.a_addr  (bus_addr),
		.a_wdata (shift_ff),
		.a_rdata (bus_rd),
		.b_we    (cpu_we),
		.b_addr  (ram_idx_ff),
		.b_wdata (reg_wdata),
		.b_rdata (cpu_rd)
	);

	// bus protocol engine
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff     <= ST_IDLE;
			shift_ff     <= `ISE_RST_BYTE;
			bit_cnt_ff   <= 4'h0;
			is_addr_ff   <= 1'b0;
			rd_dir_ff    <= 1'b0;
			ack_ff       <= 1'b0;
			ack_auto_ff  <= 1'b0;
			hold_auto_ff <= 1'b0;
			hold_tx_ff   <= 1'b0;
			m_ack_ff     <= 1'b0;
			scl_oe_n_ff  <= 1'b1;
			sda_oe_n_ff  <= 1'b1;
		end else if (!cfg_en_ff || start_det || stop_det) begin
			// enable gates the whole engine
			state_ff    <= (cfg_en_ff && start_det) ? ST_RX : ST_IDLE;
			bit_cnt_ff  <= 4'h0;
			is_addr_ff  <= 1'b1;
			scl_oe_n_ff <= 1'b1;
			sda_oe_n_ff <= 1'b1;
		end else begin
			case (state_ff)
				ST_RX: begin
					if (scl_rise) begin
						shift_ff   <= {shift_ff[6:0], sda_q};
						bit_cnt_ff <= bit_cnt_ff + 4'h1;
					end
					if (rx_end) begin
						ack_auto_ff  <= rx_ack;
						hold_auto_ff <= (ram_en & ~is_addr_ff) |
						                (is_addr_ff & auto_en);
						if (is_addr_ff) begin
							rd_dir_ff <= shift_ff[0];
						end
						if (rx_stall) begin
							state_ff    <= ST_HOLD;
							scl_oe_n_ff <= 1'b0;
							hold_tx_ff  <= 1'b0;
						end else begin
							state_ff    <= ST_ACK;
							ack_ff      <= rx_ack;
							sda_oe_n_ff <= ~rx_ack;
						end
					end
				end
				ST_HOLD: begin
					// released once the CPU writes status/control
					if (scr_wr) begin
						scl_oe_n_ff <= 1'b1;
						if (hold_tx_ff) begin
							state_ff    <= ST_TX;
							shift_ff    <= tx_src;
							sda_oe_n_ff <= tx_src[7];
							bit_cnt_ff  <= 4'h0;
						end else begin
							state_ff    <= ST_ACK;
							ack_ff      <= hold_ack;
							sda_oe_n_ff <= ~hold_ack;
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						bit_cnt_ff  <= 4'h0;
						is_addr_ff  <= 1'b0;
						sda_oe_n_ff <= 1'b1;
						if (!ack_ff) begin
							state_ff <= ST_WAIT;
						end else if (rd_dir_ff) begin
							state_ff    <= ST_TX;
							shift_ff    <= tx_src;
							sda_oe_n_ff <= tx_src[7];
						end else begin
							state_ff <= ST_RX;
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (bit_cnt_ff == `ISE_LAST_TX_BIT) begin
							state_ff    <= ST_TX_ACK;
							sda_oe_n_ff <= 1'b1;
						end else begin
							shift_ff    <= {shift_ff[6:0], 1'b0};
							sda_oe_n_ff <= shift_ff[6];
							bit_cnt_ff  <= bit_cnt_ff + 4'h1;
						end
					end
				end
				ST_TX_ACK: begin
					if (scl_rise) begin
						m_ack_ff <= ~sda_q;
					end
					if (tx_end) begin
						bit_cnt_ff <= 4'h0;
						if (!m_ack_ff) begin
							state_ff <= ST_WAIT;
						end else if (tx_stall) begin
							state_ff    <= ST_HOLD;
							scl_oe_n_ff <= 1'b0;
							hold_tx_ff  <= 1'b1;
						end else begin
							state_ff    <= ST_TX;
							shift_ff    <= tx_src;
							sda_oe_n_ff <= tx_src[7];
						end
					end
				end
				ST_WAIT: begin
					sda_oe_n_ff <= 1'b1;
				end
				default: begin
					state_ff <= ST_IDLE;
				end
			endcase
		end
	end

	// window pointers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			base_ff  <= 5'h00;
			cur_ff   <= 5'h00;
			ovf_ff   <= 1'b0;
			first_ff <= 1'b0;
		end else if (start_det) begin
			cur_ff   <= base_ff;
			ovf_ff   <= 1'b0;
			first_ff <= 1'b0;
		end else if (rx_end && ram_en) begin
			if (is_addr_ff) begin
				first_ff <= ~shift_ff[0];
			end else if (first_ff) begin
				first_ff <= 1'b0;
				if (!ptr_bad) begin
					base_ff <= shift_ff[4:0];
					cur_ff  <= shift_ff[4:0];
				end
			end else if (!ovf_ff) begin
				cur_ff <= cur_ff + 5'h01;
				ovf_ff <= (cur_ff == `ISE_PTR_LAST);
			end
		end else if (tx_end && ram_en) begin
			cur_ff <= cur_ff + 5'h01;
		end
	end

	// busy and direction status
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_ff <= 1'b0;
			dir_ff  <= 1'b0;
		end else if (stop_det || !cfg_en_ff) begin
			busy_ff <= 1'b0;
		end else if (rx_end && is_addr_ff && auto_en && addr_match) begin
			busy_ff <= 1'b1;
			dir_ff  <= shift_ff[0];
		end
	end

	// software-visible control registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			xcfg_ff     <= `ISE_RST_BYTE;
			own_addr_ff <= 7'h00;
			cfg_en_ff   <= 1'b0;
			scr_ack_ff  <= 1'b0;
			ram_idx_ff  <= 5'h00;
		end else if (reg_wr) begin
			case (reg_addr)
				`ISE_OFS_XCFG:    xcfg_ff     <= reg_wdata & `ISE_XCFG_MASK;
				`ISE_OFS_ADDR:    own_addr_ff <= reg_wdata[6:0];
				`ISE_OFS_CFG:     cfg_en_ff   <= reg_wdata[`ISE_CFG_EN];
				`ISE_OFS_SCR:     scr_ack_ff  <= reg_wdata[`ISE_SCR_ACK];
				`ISE_OFS_RAM_IDX: ram_idx_ff  <= reg_wdata[4:0];
				default: begin
					// read-only and unmapped offsets ignored
				end
			endcase
		end
	end

	// byte-done and address flags: hardware set wins over clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bdf_ff   <= 1'b0;
			addrf_ff <= 1'b0;
		end else begin
			bdf_ff   <= set_bdf | (bdf_ff & ~scr_wr);
			addrf_ff <= (rx_end & is_addr_ff & ~auto_en) |
			            (addrf_ff & ~scr_wr);
		end
	end

	// data register: received bytes land here, CPU loads transmit data
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			data_ff <= `ISE_RST_BYTE;
		end else if (rx_end) begin
			data_ff <= shift_ff;
		end else if (reg_wr && (reg_addr == `ISE_OFS_DATA)) begin
			data_ff <= reg_wdata;
		end
	end

	// read port, data one cycle after the strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff <= `ISE_RST_BYTE;
		end else if (reg_rd) begin
			case (reg_addr)
				`ISE_OFS_XCFG:    rdata_ff <= xcfg_ff;
				`ISE_OFS_XSTAT:   rdata_ff <= {6'h00, dir_ff, busy_ff};
				`ISE_OFS_ADDR:    rdata_ff <= {1'b0, own_addr_ff};
				`ISE_OFS_BP:      rdata_ff <= {3'h0, base_ff};
				`ISE_OFS_CFG:     rdata_ff <= {7'h00, cfg_en_ff};
				`ISE_OFS_SCR:     rdata_ff <= {4'h0, addrf_ff, 1'b0,
				                               scr_ack_ff, bdf_ff};
				`ISE_OFS_DATA:    rdata_ff <= data_ff;
				`ISE_OFS_RAM_IDX: rdata_ff <= {3'h0, ram_idx_ff};
				`ISE_OFS_RAM_DAT: rdata_ff <= cpu_rd;
				default:          rdata_ff <= `ISE_RST_BYTE;
			endcase
		end else begin
			rdata_ff <= `ISE_RST_BYTE;
		end
	end

	// open-drain pins only ever pull low
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_lo_ff <= 1'b0;
		end else begin
			pin_lo_ff <= 1'b0;
		end
	end

	assign reg_rdata     = rdata_ff;
	assign scl_out       = pin_lo_ff;
	assign sda_out       = pin_lo_ff;
	assign scl_oe_n      = scl_oe_n_ff;
	assign sda_oe_n      = sda_oe_n_ff;
	assign byte_done_irq = bdf_ff;
	assign bus_state     = state_ff;
endmodule : ise_ctrl

// ==== include/ise_params.svh ====
`ifndef ISE_PARAMS_SVH
`define ISE_PARAMS_SVH

// register offsets
`define ISE_OFS_XCFG     8'hc8
`define ISE_OFS_XSTAT    8'hc9
`define ISE_OFS_ADDR     8'hca
`define ISE_OFS_BP       8'hcb
`define ISE_OFS_CFG      8'hd6
`define ISE_OFS_SCR      8'hd7
`define ISE_OFS_DATA     8'hd8
`define ISE_OFS_RAM_IDX  8'hd9
`define ISE_OFS_RAM_DAT  8'hda

// field positions
`define ISE_XCFG_AUTO    0
`define ISE_XCFG_RAM     1
`define ISE_XCFG_SUP     3
`define ISE_CFG_EN       0
`define ISE_SCR_BDF      0
`define ISE_SCR_ACK      1
`define ISE_SCR_ADDRF    3

// writable masks and reset values
`define ISE_XCFG_MASK    8'h0b
`define ISE_ADDR_MASK    8'h7f
`define ISE_RST_BYTE     8'h00

// window limits and byte framing
`define ISE_PTR_MAX      8'h1f
`define ISE_PTR_LAST     5'h1f
`define ISE_BYTE_BITS    4'h8
`define ISE_LAST_TX_BIT  4'h7

`endif

// ==== include/ise_pkg.sv ====
package ise_pkg;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_RX     = 3'b001,
		ST_HOLD   = 3'b010,
		ST_ACK    = 3'b011,
		ST_TX     = 3'b100,
		ST_TX_ACK = 3'b101,
		ST_WAIT   = 3'b110
	} ise_state_t;

	typedef logic [4:0] ise_ptr_t;

endpackage : ise_pkg

// ==== rtl/ise_pin_sync.sv ====
`timescale 1ns/1ps
module ise_pin_sync #(
	parameter int W = 2
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;

	// idle bus level is high
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_ff <= '1;
			s2_ff <= '1;
			s3_ff <= '1;
		end else begin
			s1_ff <= din;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// change counts once stages two and three agree
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					dout[i] <= 1'b1;
				end else if (s2_ff[i] == s3_ff[i]) begin
					dout[i] <= s3_ff[i];
				end
			end
		end
	endgenerate
endmodule : ise_pin_sync

// ==== rtl/ise_ram.sv ====
`timescale 1ns/1ps
module ise_ram #(
	parameter int AW = 5,
	parameter int DW = 8
) (
	input  wire logic          clk,
	input  wire logic          a_we,
	input  wire logic [AW-1:0] a_addr,
	input  wire logic [DW-1:0] a_wdata,
	output logic      [DW-1:0] a_rdata,
	input  wire logic          b_we,
	input  wire logic [AW-1:0] b_addr,
	input  wire logic [DW-1:0] b_wdata,
	output logic      [DW-1:0] b_rdata
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	// port a wins a same-address collision
	always_ff @(posedge clk) begin
		if (a_we) begin
			mem[a_addr] <= a_wdata;
		end
		if (b_we && !(a_we && (a_addr == b_addr))) begin
			mem[b_addr] <= b_wdata;
		end
	end

	assign a_rdata = mem[a_addr];
	assign b_rdata = mem[b_addr];
endmodule : ise_ram

// ==== tb/ise_ctrl_assertions.sv ====
`timescale 1ns/1ps
module ise_ctrl_chk (
	input wire logic               clk,
	input wire logic               reset_n,
	input wire logic [7:0]         reg_addr,
	input wire logic [7:0]         reg_wdata,
	input wire logic               reg_wr,
	input wire logic               reg_rd,
	input wire logic [7:0]         reg_rdata,
	input wire logic               scl_in,
	input wire logic               sda_in,
	input wire logic               scl_out,
	input wire logic               scl_oe_n,
	input wire logic               sda_out,
	input wire logic               sda_oe_n,
	input wire logic               byte_done_irq,
	input wire ise_pkg::ise_state_t bus_state
);
	import ise_pkg::*;
	logic [3:0] xcfg_ff;
	logic [6:0] addr_ff;
	logic       rd_c8;
	logic       rd_c9;
	logic       rd_ca;
	logic       rd_cb;
	logic       scr_wr;

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	assign rd_c8 = reg_rd && reg_addr == 8'hc8;
	assign rd_c9 = reg_rd && reg_addr == 8'hc9;
	assign rd_ca = reg_rd && reg_addr == 8'hca;
	assign rd_cb = reg_rd && reg_addr == 8'hcb;
	assign scr_wr = reg_wr && reg_addr == 8'hd7;

	// shadow of the writable config bits
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			xcfg_ff <= 4'h0;
		else if (reg_wr && reg_addr == 8'hc8)
			xcfg_ff <= reg_wdata[3:0] & 4'hb;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			addr_ff <= 7'h00;
		else if (reg_wr && reg_addr == 8'hca)
			addr_ff <= reg_wdata[6:0];
	end

	cfg_read_a: assert property (
		$past(rd_c8) |-> reg_rdata == {4'h0, xcfg_ff})
		else $error("config readback wrong");
	stat_rsvd_a: assert property (
		$past(rd_c9) |-> reg_rdata[7:2] == 6'h00)
		else $error("status upper bits set");
	addr_read_a: assert property (
		$past(rd_ca) |-> reg_rdata == {1'b0, addr_ff})
		else $error("own address readback wrong");
	bp_rsvd_a: assert property (
		$past(rd_cb) |-> reg_rdata[7:5] == 3'h0)
		else $error("base pointer upper bits set");
	win_nostall_a: assert property (
		xcfg_ff == 4'hb |-> scl_oe_n)
		else $error("stall in window mode");
	stall_irq_a: assert property (
		$fell(scl_oe_n) |-> ##[0:2] byte_done_irq)
		else $error("stall without byte done");
	stall_hold_a: assert property (
		$rose(scl_oe_n) |-> $past(scr_wr) || $past(scr_wr, 2))
		else $error("stall released without service");
	irq_clear_a: assert property (
		$fell(byte_done_irq) |-> $past(scr_wr) || $past(scr_wr, 2))
		else $error("byte done dropped without service");
	sup_noirq_a: assert property (
		$rose(byte_done_irq) |-> xcfg_ff != 4'hb)
		else $error("byte done while suppressed");
endmodule : ise_ctrl_chk

bind ise_ctrl ise_ctrl_chk u_chk (
	.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .scl_in(scl_in), .sda_in(sda_in),
	.scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_out(sda_out),
	.sda_oe_n(sda_oe_n), .byte_done_irq(byte_done_irq),
	.bus_state(bus_state)
);

// ==== tb/ise_i2c_master.sv ====
`timescale 1ns/1ps
module ise_i2c_master (
	output logic      scl_m,
	output logic      sda_m,
	input  wire logic scl_w,
	input  wire logic sda_w
);
	initial begin
		scl_m = 1'b1;
		sda_m = 1'b1;
	end

	// start or repeated start, also before every read
	task start;
		#2 sda_m = 1'b1;
		#40 scl_m = 1'b1;
		#40 sda_m = 1'b0;
		#40 scl_m = 1'b0;
	endtask : start

	task stop;
		#40 sda_m = 1'b0;
		#40 scl_m = 1'b1;
		#40 sda_m = 1'b1;
		#40;
	endtask : stop

	// one bit, waits out clock stretching
	task bitx(input logic b, output logic r);
		#20 sda_m = b;
		#40 scl_m = 1'b1;
		for (int n = 0; n < 5000 && scl_w !== 1'b1; n++)
			#10;
		#20 r = sda_w;
		scl_m = 1'b0;
	endtask : bitx

	task wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(d[i], r);
		bitx(1'b1, r);
		ack = ~r;
	endtask : wbyte

	task rbyte(input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, r);
			d[i] = r;
		end
		bitx(nack, r);
	endtask : rbyte
endmodule : ise_i2c_master

// ==== tb/ise_ctrl_tb.sv ====
`timescale 1ns/1ps
module ise_ctrl_tb;
	import ise_pkg::*;
	typedef struct packed {
		logic       w;
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] e;
	} ise_row_t;
	logic       clk;
	logic       reset_n;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic       scl_out;
	logic       scl_oe_n;
	logic       sda_out;
	logic       sda_oe_n;
	logic       byte_done_irq;
	logic       scl_m;
	logic       sda_m;
	logic       scl_w;
	logic       sda_w;
	logic       ack;
	logic [7:0] v;
	ise_state_t bus_state;
	int         miscompares = 0;
	int         tests_run = 0;
	ise_row_t   rows [11] = '{
		'{0, 8'hc8, 8'h00, 8'h00}, '{0, 8'hc9, 8'h00, 8'h00},
		'{0, 8'hca, 8'h00, 8'h00}, '{0, 8'hcb, 8'h00, 8'h00},
		'{1, 8'hc8, 8'h0b, 8'h0b}, '{1, 8'hc8, 8'h00, 8'h00},
		'{1, 8'hca, 8'h7f, 8'h7f}, '{1, 8'hc9, 8'h03, 8'h00},
		'{1, 8'hcb, 8'h1f, 8'h00}, '{0, 8'h10, 8'h00, 8'h00},
		'{1, 8'h10, 8'h55, 8'h00}};

	assign scl_w = scl_m & (scl_oe_n | scl_out);
	assign sda_w = sda_m & (sda_oe_n | sda_out);

	ise_ctrl DUT (
		.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .scl_in(scl_w), .sda_in(sda_w),
		.scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .byte_done_irq(byte_done_irq),
		.bus_state(bus_state));
	ise_i2c_master m (.scl_m(scl_m), .sda_m(sda_m), .scl_w(scl_w),
		.sda_w(sda_w));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task rc(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask : rc

	task ram_chk(input logic [7:0] a, input logic [7:0] e);
		wr(8'hd9, a);
		rc(8'hda, e);
	endtask : ram_chk

	// firmware side: wait for byte done, check stall, acknowledge
	task serve(input int n, input logic [7:0] e, input logic [7:0] s);
		for (int i = 0; i < n; i++) begin
			for (int k = 0; k < 3000 && byte_done_irq !== 1'b1; k++)
				@(negedge clk);
			repeat (3) @(negedge clk);
			chk({7'h00, scl_oe_n}, 8'h00);
			chk({6'h00, scl_out, sda_out}, 8'h00);
			if (i == 0 && e !== 8'h00) begin
				rc(8'hd8, e);
				rc(8'hd7, s);
			end
			wr(8'hd7, 8'h02);
			repeat (2) @(negedge clk);
		end
	endtask : serve

	task end_of_test;
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test

	initial begin
		#500_000;
		miscompares++;
		end_of_test();
	end

	initial begin
		reset_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		foreach (rows[i]) begin
			if (rows[i].w)
				wr(rows[i].a, rows[i].d);
			rc(rows[i].a, rows[i].e);
		end
		wr(8'hd6, 8'h01);
		wr(8'hca, 8'h50);
		wr(8'hd9, 8'h00);
		wr(8'hda, 8'h5a);
		ram_chk(8'h00, 8'h5a);
		rc(8'hda, 8'h5a);
		wr(8'hc8, 8'h0b);
		// window write running past the last location
		m.start();
		m.wbyte(8'ha0, ack);
		chk({7'h00, ack}, 8'h01);
		rc(8'hc9, 8'h01);
		m.wbyte(8'h1e, ack);
		chk({7'h00, ack}, 8'h01);
		m.wbyte(8'h11, ack);
		m.wbyte(8'h22, ack);
		m.wbyte(8'h33, ack);
		m.stop();
		rc(8'hc9, 8'h00);
		rc(8'hcb, 8'h1e);
		ram_chk(8'h1e, 8'h11);
		ram_chk(8'h1f, 8'h22);
		ram_chk(8'h00, 8'h5a);
		chk({7'h00, byte_done_irq}, 8'h00);
		// read, then repeated start read from the same base
		m.start();
		m.wbyte(8'ha1, ack);
		rc(8'hc9, 8'h03);
		m.rbyte(1'b0, v);
		chk(v, 8'h11);
		m.rbyte(1'b1, v);
		chk(v, 8'h22);
		m.start();
		m.wbyte(8'ha1, ack);
		m.rbyte(1'b1, v);
		chk(v, 8'h11);
		m.stop();
		rc(8'hcb, 8'h1e);
		m.start();
		m.wbyte(8'ha0, ack);
		m.wbyte(8'h20, ack);
		chk({7'h00, ack}, 8'h00);
		m.stop();
		m.start();
		m.wbyte(8'ha2, ack);
		chk({7'h00, ack}, 8'h00);
		m.stop();
		rc(8'hc9, 8'h00);
		// firmware address compare, window mode, suppressed
		wr(8'hc8, 8'h0a);
		fork
			begin
				m.start();
				m.wbyte(8'ha4, ack);
				m.wbyte(8'h03, ack);
				m.wbyte(8'h77, ack);
				m.stop();
			end
			serve(1, 8'ha4, 8'h09);
		join
		chk({7'h00, byte_done_irq}, 8'h00);
		rc(8'hcb, 8'h03);
		ram_chk(8'h03, 8'h77);
		// compatibility with suppress set, then auto match only
		for (int j = 0; j < 2; j++) begin
			wr(8'hc8, j ? 8'h09 : 8'h08);
			fork
				begin
					m.start();
					m.wbyte(8'ha0, ack);
					m.wbyte(8'h5c, ack);
					m.stop();
				end
				serve(2, j ? 8'h00 : 8'ha0, 8'h0b);
			join
			chk({7'h00, ack}, 8'h01);
		end
		rc(8'hd8, 8'h5c);
		// legacy read, firmware loads the transmit byte
		wr(8'hc8, 8'h00);
		fork
			begin
				m.start();
				m.wbyte(8'ha1, ack);
				m.rbyte(1'b1, v);
				m.stop();
			end
			begin
				for (int k = 0; k < 3000 &&
				     byte_done_irq !== 1'b1; k++)
					@(negedge clk);
				wr(8'hd8, 8'hc3);
				wr(8'hd7, 8'h02);
			end
		join
		chk(v, 8'hc3);
		chk({7'h00, byte_done_irq}, 8'h01);
		wr(8'hd7, 8'h00);
		// reset in mid-run
		wr(8'hc8, 8'h0b);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		rc(8'hc8, 8'h00);
		rc(8'hca, 8'h00);
		chk({5'h00, bus_state}, {5'h00, ST_IDLE});
		end_of_test();
	end
endmodule : ise_ctrl_tb
